// *** src/sse_pkg.sv ***
// Shared types and constants for the skip and subtract execution block.
package sse_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int BIT_W = 3;

    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] INC_STEP = 8'h01;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 8'h00;
    localparam int SIGN_BIT = 7;
    localparam int NIBBLE_TOP = 3;

    // Cycles a taken skip occupies, the skip itself plus the dummy slot.
    localparam int SKIP_CYCLES = 2;

    typedef enum logic [2:0] {
        SSE_OP_NOP,
        SSE_OP_INCREMENT_SKIP_ZERO,
        SSE_OP_INCREMENT_SKIP_ZERO_TO_ACC,
        SSE_OP_BIT_TEST_SKIP_NONZERO,
        SSE_OP_SUBTRACT_FROM_ACC,
        SSE_OP_SUBTRACT_INTO_MEMORY,
        SSE_OP_SUBTRACT_IMMEDIATE,
        SSE_OP_LOAD_ACC
    } sse_op_t;

    typedef struct packed {
        logic overflow_flag;
        logic zero_flag;
        logic aux_carry_flag;
        logic carry_flag;
    } sse_flags_t;

    localparam sse_flags_t FLAGS_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic valid;
        sse_op_t op;
        logic [ADDR_W-1:0] addr;
        logic [BIT_W-1:0] bit_sel;
        logic [DATA_W-1:0] mem_data;
        logic [DATA_W-1:0] imm;
    } sse_req_t;

    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } sse_wr_t;

    localparam sse_wr_t WR_RESET = '{1'b0, ADDR_RESET, ZERO_BYTE};

    typedef struct packed {
        logic [DATA_W-1:0] diff;
        sse_flags_t flags;
    } sse_sub_t;

endpackage : sse_pkg

// *** src/sse_exec.sv ***
// Execution unit for increment-skip, bit-test-skip and subtract instructions.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Increment-skip writes memory byte plus one back; skips when new byte is zero.
// - Increment-skip-to-accumulator loads byte plus one into accumulator; skips on zero.
// - Increment-skip-to-accumulator never writes data memory.
// - Bit-test-skip skips when selected bit is one; memory and flags untouched.
// - Taken skip turns the following instruction into a dummy slot: two cycles.
// - Untaken skip lets the following instruction execute normally.
// - Subtract from accumulator stores difference in accumulator, updates all four flags.
// - Subtract into memory writes difference to the addressed byte, updates all flags.
// - Subtract immediate takes the instruction constant from accumulator, updates flags.
// - Carry is cleared on borrow and set when difference is zero or positive.
module sse_exec (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire sse_pkg::sse_req_t req,
    output logic [sse_pkg::DATA_W-1:0] accumulator,
    output sse_pkg::sse_flags_t flags,
    output sse_pkg::sse_wr_t mem_wr,
    output logic retired,
    output logic skip_taken,
    output logic dummy_slot
);

    // A request is taken at an enabled rising edge while the unit is in run, and every result
    // shows one edge later. The write strobe, retired, skip and dummy flags last one enabled
    // edge; with the clock enable low they stand frozen together with the rest of the state.
    // The memory operand must arrive with the request, since the unit keeps no copy of memory.

    typedef enum logic {
        SSE_ST_RUN,
        SSE_ST_DUMMY
    } sse_state_t;

    // All state lives in one register, so reset and clock enable treat it as a unit.
    typedef struct packed {
        sse_state_t state;
        logic [sse_pkg::DATA_W-1:0] accumulator;
        sse_pkg::sse_flags_t flags;
        sse_pkg::sse_wr_t mem_wr;
        logic retired;
        logic skip_taken;
        logic dummy_slot;
    } sse_regs_t;

    localparam sse_regs_t REGS_RESET = '{
        SSE_ST_RUN,
        sse_pkg::ACC_RESET,
        sse_pkg::FLAGS_RESET,
        sse_pkg::WR_RESET,
        1'b0,
        1'b0,
        1'b0
    };

    // Strobes last one enabled edge, so each step starts with all of them low.
    function automatic sse_regs_t sse_clear_pulses(
        input sse_regs_t regs
    );
        sse_regs_t cleared;
        cleared = regs;
        cleared.mem_wr.we = 1'b0;
        cleared.retired = 1'b0;
        cleared.skip_taken = 1'b0;
        cleared.dummy_slot = 1'b0;
        return cleared;
    endfunction : sse_clear_pulses

    // The carry out is dropped on purpose: an all-ones byte wraps to zero, which is exactly
    // the case that makes the increment skips fire.
    function automatic logic [sse_pkg::DATA_W-1:0] sse_increment(
        input logic [sse_pkg::DATA_W-1:0] value
    );
        logic [sse_pkg::DATA_W:0] sum;
        sum = {1'b0, value} + {1'b0, sse_pkg::INC_STEP};
        return sum[sse_pkg::DATA_W-1:0];
    endfunction : sse_increment

    // Zero test shared by the increment skips and the zero flag.
    function automatic logic sse_is_zero(
        input logic [sse_pkg::DATA_W-1:0] value
    );
        return value == sse_pkg::ZERO_BYTE;
    endfunction : sse_is_zero

    // The select is three bits wide, so it can never point past the byte.
    function automatic logic sse_bit_of(
        input logic [sse_pkg::DATA_W-1:0] value,
        input logic [sse_pkg::BIT_W-1:0] sel
    );
        return value[sel];
    endfunction : sse_bit_of

    // Signed overflow of a minus b: opposite operand signs and a result that left a's sign.
    function automatic logic sse_overflow(
        input logic [sse_pkg::DATA_W-1:0] a,
        input logic [sse_pkg::DATA_W-1:0] b,
        input logic [sse_pkg::DATA_W-1:0] diff
    );
        logic signs_differ;
        logic sign_flipped;
        signs_differ = a[sse_pkg::SIGN_BIT] != b[sse_pkg::SIGN_BIT];
        sign_flipped = diff[sse_pkg::SIGN_BIT] != a[sse_pkg::SIGN_BIT];
        return signs_differ && sign_flipped;
    endfunction : sse_overflow

    // The immediate form is the only one whose subtrahend does not come from memory.
    function automatic logic [sse_pkg::DATA_W-1:0] sse_subtrahend(
        input sse_pkg::sse_req_t q
    );
        logic [sse_pkg::DATA_W-1:0] operand;
        if (q.op == sse_pkg::SSE_OP_SUBTRACT_IMMEDIATE) begin
            operand = q.imm;
        end else begin
            operand = q.mem_data;
        end
        return operand;
    endfunction : sse_subtrahend

    // Skip condition per opcode; every opcode outside the three skips never skips.
    function automatic logic sse_skip_condition(
        input sse_pkg::sse_op_t op,
        input logic [sse_pkg::DATA_W-1:0] mem_data,
        input logic [sse_pkg::BIT_W-1:0] sel
    );
        logic hit;
        hit = 1'b0;
        case (op)
            sse_pkg::SSE_OP_INCREMENT_SKIP_ZERO: begin
                hit = sse_is_zero(sse_increment(mem_data));
            end
            sse_pkg::SSE_OP_INCREMENT_SKIP_ZERO_TO_ACC: begin
                hit = sse_is_zero(sse_increment(mem_data));
            end
            sse_pkg::SSE_OP_BIT_TEST_SKIP_NONZERO: begin
                hit = sse_bit_of(mem_data, sel);
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction : sse_skip_condition

    // Only these three opcodes own the flags; everything else leaves them alone.
    function automatic logic sse_is_subtract_op(
        input sse_pkg::sse_op_t op
    );
        logic hit;
        hit = 1'b0;
        case (op)
            sse_pkg::SSE_OP_SUBTRACT_FROM_ACC: begin
                hit = 1'b1;
            end
            sse_pkg::SSE_OP_SUBTRACT_INTO_MEMORY: begin
                hit = 1'b1;
            end
            sse_pkg::SSE_OP_SUBTRACT_IMMEDIATE: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction : sse_is_subtract_op

    // Increment-skip and subtract-into-memory are the only opcodes that write memory.
    function automatic logic sse_writes_memory(
        input sse_pkg::sse_op_t op
    );
        logic hit;
        hit = 1'b0;
        case (op)
            sse_pkg::SSE_OP_INCREMENT_SKIP_ZERO: begin
                hit = 1'b1;
            end
            sse_pkg::SSE_OP_SUBTRACT_INTO_MEMORY: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        return hit;
    endfunction : sse_writes_memory

    // A met skip parks the unit in the dummy slot for exactly one enabled edge.
    function automatic sse_state_t sse_next_state(
        input logic skip
    );
        sse_state_t state;
        if (skip) begin
            state = SSE_ST_DUMMY;
        end else begin
            state = SSE_ST_RUN;
        end
        return state;
    endfunction : sse_next_state

    // Minuend a, subtrahend b; the same arithmetic serves all three subtract forms.
    function automatic sse_pkg::sse_sub_t sse_subtract(
        input logic [sse_pkg::DATA_W-1:0] a,
        input logic [sse_pkg::DATA_W-1:0] b
    );
        sse_pkg::sse_sub_t r;
        logic [sse_pkg::DATA_W:0] wide;
        logic [sse_pkg::NIBBLE_TOP+1:0] low;
        wide = {1'b0, a} - {1'b0, b};
        low = {1'b0, a[sse_pkg::NIBBLE_TOP:0]} - {1'b0, b[sse_pkg::NIBBLE_TOP:0]};
        r.diff = wide[sse_pkg::DATA_W-1:0];
        // A borrow out of the top shows as the extra bit; carry is its inverse.
        r.flags.carry_flag = ~wide[sse_pkg::DATA_W];
        r.flags.aux_carry_flag = ~low[sse_pkg::NIBBLE_TOP+1];
        r.flags.zero_flag = sse_is_zero(r.diff);
        r.flags.overflow_flag = sse_overflow(a, b, r.diff);
        return r;
    endfunction : sse_subtract

    sse_regs_t cur;
    sse_regs_t next_cur;

    always_comb begin
        logic [sse_pkg::DATA_W-1:0] incremented;
        logic skip_cond;
        sse_pkg::sse_sub_t sub_res;
        incremented = sse_increment(req.mem_data);
        skip_cond = sse_skip_condition(req.op, req.mem_data, req.bit_sel);
        sub_res = sse_subtract(cur.accumulator, sse_subtrahend(req));

        next_cur = sse_clear_pulses(cur);

        case (cur.state)
            SSE_ST_DUMMY: begin
                // The fetched successor is dropped unexecuted in this slot.
                next_cur.dummy_slot = 1'b1;
                next_cur.state = SSE_ST_RUN;
            end
            default: begin
                if (req.valid) begin
                    next_cur.retired = 1'b1;
                    case (req.op)
                        sse_pkg::SSE_OP_INCREMENT_SKIP_ZERO: begin
                            next_cur.mem_wr.addr = req.addr;
                            next_cur.mem_wr.data = incremented;
                        end
                        sse_pkg::SSE_OP_INCREMENT_SKIP_ZERO_TO_ACC: begin
                            // Memory write stays low here.
                            next_cur.accumulator = incremented;
                        end
                        sse_pkg::SSE_OP_SUBTRACT_FROM_ACC: begin
                            next_cur.accumulator = sub_res.diff;
                        end
                        sse_pkg::SSE_OP_SUBTRACT_INTO_MEMORY: begin
                            next_cur.mem_wr.addr = req.addr;
                            next_cur.mem_wr.data = sub_res.diff;
                        end
                        sse_pkg::SSE_OP_SUBTRACT_IMMEDIATE: begin
                            next_cur.accumulator = sub_res.diff;
                        end
                        sse_pkg::SSE_OP_LOAD_ACC: begin
                            next_cur.accumulator = req.imm;
                        end
                        default: begin
                            // No operation and bit test change no register here.
                            next_cur.accumulator = cur.accumulator;
                        end
                    endcase
                    next_cur.mem_wr.we = sse_writes_memory(req.op);
                    next_cur.skip_taken = skip_cond;
                    // Only the three subtracts touch the flags.
                    if (sse_is_subtract_op(req.op)) begin
                        next_cur.flags = sub_res.flags;
                    end
                    // An untaken skip leaves the state in run, so the next one executes.
                    next_cur.state = sse_next_state(next_cur.skip_taken);
                end
            end
        endcase
    end

    // Clock enable low freezes every flop, including the one-cycle pulses.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cur <= REGS_RESET;
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end

    assign accumulator = cur.accumulator;
    assign flags = cur.flags;
    assign mem_wr = cur.mem_wr;
    assign retired = cur.retired;
    assign skip_taken = cur.skip_taken;
    assign dummy_slot = cur.dummy_slot;

endmodule : sse_exec

`default_nettype wire

// *** test/sse_exec_monitor.sv ***
// Port-level assertions for the skip and subtract execution unit.
`timescale 1ns/1ps
`default_nettype none
module sse_exec_monitor (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire sse_pkg::sse_req_t req,
    input wire logic [7:0] accumulator,
    input wire sse_pkg::sse_flags_t flags,
    input wire sse_pkg::sse_wr_t mem_wr,
    input wire logic retired,
    input wire logic skip_taken,
    input wire logic dummy_slot
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // A set skip_taken means this edge is the dummy slot, so no request is taken.
    wire logic go = clk_en && req.valid && !skip_taken;
    wire logic [2:0] op = req.op;
    wire logic [7:0] inc = req.mem_data + 8'h01;
    wire logic [7:0] sb = (op == 3'h6) ? req.imm : req.mem_data;
    wire logic [7:0] dif = accumulator - sb;
    wire logic cy = accumulator >= sb;
    wire logic bv = req.mem_data[req.bit_sel];
    wire logic sub = go && op >= 3'h4 && op <= 3'h6;
    property p_inc;
        go && op == 3'h1 |=> mem_wr.we && mem_wr.data == $past(inc)
            && skip_taken == ($past(inc) == 8'h00);
    endproperty
    a_inc: assert property (p_inc) else $error("increment skip wrong");
    property p_inca;
        go && op == 3'h2 |=> accumulator == $past(inc) && skip_taken == (accumulator == 8'h00);
    endproperty
    a_inca: assert property (p_inca) else $error("increment to acc wrong");
    property p_inca_nowr;
        go && op == 3'h2 |=> !mem_wr.we;
    endproperty
    a_inca_nowr: assert property (p_inca_nowr) else $error("memory written");
    property p_bit;
        go && op == 3'h3 |=> skip_taken == $past(bv) && !mem_wr.we;
    endproperty
    a_bit: assert property (p_bit) else $error("bit test skip wrong");
    property p_noflag;
        go && !sub |=> $stable(flags);
    endproperty
    a_noflag: assert property (p_noflag) else $error("flags moved");
    property p_dummy;
        clk_en && skip_taken |=> dummy_slot && !retired && !mem_wr.we;
    endproperty
    a_dummy: assert property (p_dummy) else $error("no dummy slot");
    property p_nodummy;
        clk_en && !skip_taken |=> !dummy_slot;
    endproperty
    a_nodummy: assert property (p_nodummy) else $error("stray dummy slot");
    property p_subacc;
        go && (op == 3'h4 || op == 3'h6) |=> accumulator == $past(dif);
    endproperty
    a_subacc: assert property (p_subacc) else $error("difference wrong");
    property p_subtract_into_memory;
        go && op == 3'h5 |=> mem_wr.we && mem_wr.data == $past(dif)
            && accumulator == $past(accumulator);
    endproperty
    a_subtract_into_memory: assert property (p_subtract_into_memory) else $error("memory difference wrong");
    property p_carry;
        sub |=> flags.carry_flag == $past(cy) && flags.zero_flag == (mem_wr.we ?
            mem_wr.data == 8'h00 : accumulator == 8'h00);
    endproperty
    a_carry: assert property (p_carry) else $error("carry or zero wrong");
    c_skip: cover property (go && op == 3'h1 ##1 skip_taken ##1 dummy_slot);
    c_borrow: cover property (sub ##1 !flags.carry_flag);
    c_bit: cover property (go && op == 3'h3 ##1 skip_taken);
endmodule : sse_exec_monitor
bind sse_exec sse_exec_monitor mon (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .req(req), .accumulator(accumulator), .flags(flags), .mem_wr(mem_wr),
    .retired(retired), .skip_taken(skip_taken), .dummy_slot(dummy_slot));
`default_nettype wire

// *** test/tb_sse_exec.sv ***
// Randomised self-checking bench for the skip and subtract execution unit.
`timescale 1ns/1ps
`default_nettype none
module tb_sse_exec;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b0;
    sse_pkg::sse_req_t req = '0;
    sse_pkg::sse_req_t r;
    logic [7:0] accumulator;
    sse_pkg::sse_flags_t flags;
    sse_pkg::sse_wr_t mem_wr;
    logic retired, skip_taken, dummy_slot, e;
    int fails = 0;
    int tests_run = 0;
    int acc = 0, f = 0, we = 0, wd = 0, wa = 0, ret = 0, sk = 0, dm = 0, pend = 0;
    sse_exec dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .req(req),
        .accumulator(accumulator), .flags(flags), .mem_wr(mem_wr), .retired(retired),
        .skip_taken(skip_taken), .dummy_slot(dummy_slot));
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [8:0] s, input logic [8:0] x);
        tests_run++;
        if (s !== x) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, x);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    // Reference model: one call per enabled edge, pulses cleared unless re-raised.
    task automatic step(input sse_pkg::sse_req_t q);
        int b, d;
        b = (q.op == 3'h6) ? int'(q.imm) : int'(q.mem_data);
        d = acc - b;
        we = 0; ret = 0; sk = 0; dm = 0;
        if (pend != 0) begin
            dm = 1;
            pend = 0;
        end else if (q.valid) begin
            ret = 1;
            case (q.op)
                3'h1: begin we = 1; wa = q.addr; wd = (q.mem_data + 1) % 256; sk = (wd == 0); end
                3'h2: begin acc = (q.mem_data + 1) % 256; sk = (acc == 0); end
                3'h3: sk = q.mem_data[q.bit_sel];
                3'h7: acc = q.imm;
                3'h4, 3'h5, 3'h6: begin
                    f = 8 * (((acc ^ b) & (acc ^ d) & 128) != 0) + 4 * ((d & 255) == 0)
                        + 2 * ((acc & 15) >= (b & 15)) + (acc >= b);
                    if (q.op == 3'h5) begin we = 1; wa = q.addr; wd = d & 255; end
                    else acc = d & 255;
                end
                default: ;
            endcase
            pend = sk;
        end
    endtask : step
    initial begin
        void'($urandom(60));
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int t = 0; t < 2; t++) begin
            repeat (600) begin
                @(posedge clk_sys);
                r = sse_pkg::sse_req_t'(($bits(sse_pkg::sse_req_t))'($urandom));
                // All-ones bytes make the increment skips actually wrap to zero.
                if ($urandom_range(0, 3) == 0) r.mem_data = 8'hff;
                e = (t == 0) || ($urandom_range(0, 3) != 0);
                req <= r;
                clk_en <= e;
                #1;
                chk({1'b0, accumulator}, 9'(acc));
                chk({5'h0, flags}, 9'(f));
                chk({mem_wr.we, mem_wr.we ? mem_wr.data : 8'h00}, 9'(we * 256 + we * wd));
                chk({6'h0, retired, skip_taken, dummy_slot}, 9'(ret * 4 + sk * 2 + dm));
                chk({1'b0, mem_wr.addr}, 9'(wa));
                if (e) step(r);
            end
            $display("test %0d done", t);
        end
        tally_and_finish();
    end
endmodule : tb_sse_exec
`default_nettype wire
